// ===== include/sisb_defs.vh
// Register offsets, field positions, reset values and codes of the block.
`ifndef SISB_DEFS_VH
`define SISB_DEFS_VH
// Register offsets.
`define SISB_OFS_VEC    8'hF4
`define SISB_OFS_MATCH  8'hF5
`define SISB_OFS_MASK   8'hF6
`define SISB_OFS_PEND   8'hF7
`define SISB_OFS_DATA   8'hF8
`define SISB_OFS_CTRL   8'hF9
`define SISB_OFS_FMT    8'hFA
// Pending flag positions.
`define SISB_P_OVR      7
`define SISB_P_FRM      6
`define SISB_P_PAR      5
`define SISB_P_ADR      4
`define SISB_P_BRK      3
`define SISB_P_WRD      2
`define SISB_P_HEM      1
`define SISB_P_SEM      0
// Mask register positions.
`define SISB_M_BSN      7
`define SISB_M_REOB     6
`define SISB_M_TEOB     5
`define SISB_M_ERR      4
`define SISB_M_ADR      3
`define SISB_M_BRK      2
`define SISB_M_RXW      1
`define SISB_M_TXW      0
// Control and format register positions.
`define SISB_C_ASH      7
`define SISB_C_RXDMA    4
`define SISB_C_TXDMA    3
`define SISB_F_ASL      7
`define SISB_F_EVEN     6
`define SISB_F_PEN      5
`define SISB_F_WL_HI    1
`define SISB_F_WL_LO    0
// Vector fields.
`define SISB_V_BASE_HI  7
`define SISB_V_BASE_LO  3
// Reset values.
`define SISB_MASK_RST   8'h00
`define SISB_PEND_RST   8'h00
`define SISB_CTRL_RST   8'h00
`define SISB_FMT_RST    8'h03
`define SISB_BYTE_ZERO  8'h00
`define SISB_BASE_RST   5'h00
// Source codes.
`define SISB_SRC_ERR    2'h0
`define SISB_SRC_BRKADR 2'h1
`define SISB_SRC_RXD    2'h2
`define SISB_SRC_TX     2'h3
// Addressing modes, high select bit then low select bit.
`define SISB_MODE_NINTH 2'h0
`define SISB_MODE_SRCH  2'h1
`define SISB_MODE_MAT9  2'h2
`define SISB_MODE_BRK   2'h3
`endif

// ===== hw/sisb_prio.v
// Fixed-priority encoder of the four interrupt sources.
`timescale 1ns/1ns
`default_nettype none
`include "sisb_defs.vh"
module sisb_prio (
  // Gated requests.
  input  wire       req_err,
  input  wire       req_brkadr,
  input  wire       req_rxd,
  input  wire       req_tx,
  // Encoded result.
  output reg  [1:0] code,
  output wire       any
);
  assign any = req_err | req_brkadr | req_rxd | req_tx;
  always @* begin
    if (req_err) begin
      code = `SISB_SRC_ERR;
    end else if (req_brkadr) begin
      code = `SISB_SRC_BRKADR;
    end else if (req_rxd) begin
      code = `SISB_SRC_RXD;
    end else begin
      code = `SISB_SRC_TX;
    end
  end
endmodule
`default_nettype wire

// ===== hw/sisb_addr.v
// Address and character match filter of the receive path.
`timescale 1ns/1ns
`default_nettype none
`include "sisb_defs.vh"
module sisb_addr (
  // Clock and reset.
  input  wire       clk,
  input  wire       srst,
  // Received word.
  input  wire       word_done,
  input  wire [1:0] mode,
  input  wire       ninth,
  input  wire       after_break,
  input  wire       stop_ok,
  input  wire [7:0] data,
  input  wire [7:0] match_char,
  // Decision.
  output reg        addr_hit,
  output reg        transfer
);
  reg listen_reg;
  reg listen_next;
  reg is_addr;
  reg match;
  always @* begin
    match       = (data == match_char);
    is_addr     = (mode == `SISB_MODE_BRK) ? after_break : ninth;
    listen_next = listen_reg;
    addr_hit    = 1'b0;
    transfer    = 1'b0;
    case (mode)
      `SISB_MODE_SRCH: begin
        addr_hit = match;
        transfer = ~match | ~stop_ok;
      end
      `SISB_MODE_NINTH, `SISB_MODE_MAT9, `SISB_MODE_BRK: begin
        if (is_addr) begin
          addr_hit = (mode == `SISB_MODE_NINTH) | match;
          if (word_done) begin
            listen_next = addr_hit;
          end
        end
        transfer = (~is_addr & (listen_reg | (mode == `SISB_MODE_NINTH))) |
                   ~stop_ok;
      end
      default: begin
        transfer = 1'b1;
      end
    endcase
  end
  always @(posedge clk) begin
    if (srst) begin
      listen_reg <= 1'b0;
    end else begin
      listen_reg <= listen_next;
    end
  end
endmodule
`default_nettype wire

// ===== hw/sisb_top.v
// Interrupt vector, mask, pending flags and data buffers of the serial unit.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "sisb_defs.vh"
module sisb_top (
  // Clock and reset.
  input  wire       CLK,
  input  wire       SRST,
  // Register port.
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  // Receiver shift register side.
  input  wire       RX_WORD_DONE,
  input  wire [7:0] RX_SHIFT,
  input  wire       RX_NINTH,
  input  wire       RX_PARITY_BIT,
  input  wire       RX_STOP_OK,
  input  wire       RX_AFTER_BREAK,
  input  wire       RX_BREAK,
  // Transmitter shift register side.
  input  wire       TX_SHIFT_FREE,
  input  wire       TX_SHIFT_DONE,
  output reg        TX_LOAD,
  output reg  [7:0] TX_DATA,
  // DMA side.
  input  wire       RX_DMA_ACK,
  input  wire       RX_DMA_ZERO,
  input  wire       TX_DMA_ZERO,
  output reg        RX_DMA_REQ,
  output reg        TX_DMA_REQ,
  // Interrupt request.
  output reg        IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Bits used by the selected word length.
  function [7:0] wl_mask;
    input [1:0] wl;
    begin
      case (wl)
        2'h0:    wl_mask = 8'h1F;
        2'h1:    wl_mask = 8'h3F;
        2'h2:    wl_mask = 8'h7F;
        default: wl_mask = 8'hFF;
      endcase
    end
  endfunction

  // Address decode of one register.
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  reg  [4:0] base_reg;
  reg  [4:0] base_next;
  reg  [7:0] match_reg;
  reg  [7:0] match_next;
  reg  [7:0] mask_reg;
  reg  [7:0] mask_next;
  reg  [7:0] pend_reg;
  reg  [7:0] pend_next;
  reg  [7:0] rxbuf_reg;
  reg  [7:0] rxbuf_next;
  reg  [7:0] txbuf_reg;
  reg  [7:0] txbuf_next;
  reg  [7:0] ctrl_reg;
  reg  [7:0] ctrl_next;
  reg  [7:0] fmt_reg;
  reg  [7:0] fmt_next;
  reg        unread_reg;
  reg        unread_next;
  reg        full_reg;
  reg        full_next;
  reg  [7:0] rdata_next;
  reg        load_next;
  reg  [7:0] txdata_next;
  reg        irq_next;
  reg        rxreq_next;
  reg        txreq_next;

  wire [1:0] mode;
  wire       addr_hit;
  wire       transfer;
  wire [1:0] src_code;
  wire       src_any;

  reg  [7:0] pend_set;
  reg  [7:0] pend_clr;
  reg  [7:0] padded;
  reg        par_err;
  reg        rx_move;
  reg        tx_move;
  reg        wr_data;
  reg        rd_data;
  reg        rxdma_en;
  reg        txdma_en;
  reg        tx_ev;
  reg        req_err;
  reg        req_brkadr;
  reg        req_rxd;
  reg        req_tx;
  reg  [1:0] word_len;

  ////////////////////////////////////////////////////////////////////////////
  // Address filter and source encoder.

  assign mode = {ctrl_reg[`SISB_C_ASH], fmt_reg[`SISB_F_ASL]};

  sisb_addr u_addr (
    .clk         (CLK),
    .srst        (SRST),
    .word_done   (RX_WORD_DONE),
    .mode        (mode),
    .ninth       (RX_NINTH),
    .after_break (RX_AFTER_BREAK),
    .stop_ok     (RX_STOP_OK),
    .data        (RX_SHIFT),
    .match_char  (match_reg),
    .addr_hit    (addr_hit),
    .transfer    (transfer)
  );

  sisb_prio u_prio (
    .req_err    (req_err),
    .req_brkadr (req_brkadr),
    .req_rxd    (req_rxd),
    .req_tx     (req_tx),
    .code       (src_code),
    .any        (src_any)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive and transmit events.

  always @* begin
    wr_data  = WR & hit(ADDR, `SISB_OFS_DATA);
    rd_data  = RD & hit(ADDR, `SISB_OFS_DATA);
    rxdma_en = ctrl_reg[`SISB_C_RXDMA];
    txdma_en = ctrl_reg[`SISB_C_TXDMA];
    word_len = fmt_reg[`SISB_F_WL_HI:`SISB_F_WL_LO];
    rx_move  = RX_WORD_DONE & transfer;
    // The holding byte moves only once the previous load pulse is over.
    tx_move  = full_reg & TX_SHIFT_FREE & ~TX_LOAD;
    padded   = RX_SHIFT | ~wl_mask(word_len);
    par_err  = fmt_reg[`SISB_F_PEN] &
               (^(RX_SHIFT & wl_mask(word_len)) ^
                RX_PARITY_BIT ^ ~fmt_reg[`SISB_F_EVEN]);
    pend_set = `SISB_BYTE_ZERO;
    pend_set[`SISB_P_OVR] = rx_move & unread_reg;
    pend_set[`SISB_P_FRM] = RX_WORD_DONE & ~RX_STOP_OK;
    pend_set[`SISB_P_PAR] = RX_WORD_DONE & par_err;
    pend_set[`SISB_P_ADR] = RX_WORD_DONE & addr_hit;
    pend_set[`SISB_P_BRK] = RX_BREAK;
    pend_set[`SISB_P_WRD] = rx_move;
    pend_set[`SISB_P_HEM] = tx_move;
    pend_set[`SISB_P_SEM] = TX_SHIFT_DONE;
    pend_clr = `SISB_BYTE_ZERO;
    if (WR & hit(ADDR, `SISB_OFS_PEND)) begin
      pend_clr = ~WDATA;
    end
    if (RX_DMA_ACK) begin
      pend_clr[`SISB_P_WRD] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the register file.

  always @* begin
    base_next   = base_reg;
    match_next  = match_reg;
    mask_next   = mask_reg;
    ctrl_next   = ctrl_reg;
    fmt_next    = fmt_reg;
    rxbuf_next  = rxbuf_reg;
    txbuf_next  = txbuf_reg;
    if (WR & hit(ADDR, `SISB_OFS_VEC)) begin
      base_next = WDATA[`SISB_V_BASE_HI:`SISB_V_BASE_LO];
    end
    if (WR & hit(ADDR, `SISB_OFS_MATCH)) begin
      match_next = WDATA;
    end
    if (WR & hit(ADDR, `SISB_OFS_MASK)) begin
      mask_next[`SISB_M_BSN]  = WDATA[`SISB_M_BSN];
      mask_next[`SISB_M_REOB] = mask_reg[`SISB_M_REOB] &
                                WDATA[`SISB_M_REOB];
      mask_next[`SISB_M_TEOB] = mask_reg[`SISB_M_TEOB] &
                                WDATA[`SISB_M_TEOB];
      mask_next[`SISB_M_ERR:`SISB_M_TXW] = WDATA[`SISB_M_ERR:`SISB_M_TXW];
    end
    if (WR & hit(ADDR, `SISB_OFS_CTRL)) begin
      ctrl_next = WDATA;
    end
    if (WR & hit(ADDR, `SISB_OFS_FMT)) begin
      fmt_next = WDATA;
    end
    if (RX_DMA_ZERO) begin
      ctrl_next[`SISB_C_RXDMA] = 1'b0;
      mask_next[`SISB_M_REOB]  = 1'b1;
    end
    if (TX_DMA_ZERO) begin
      ctrl_next[`SISB_C_TXDMA] = 1'b0;
      mask_next[`SISB_M_TEOB]  = 1'b1;
    end
    if (rx_move) begin
      rxbuf_next = padded;
    end
    if (wr_data) begin
      txbuf_next = WDATA;
    end
    // A hardware set wins over a software clear in the same cycle.
    pend_next   = (pend_reg & ~pend_clr) | pend_set;
    unread_next = (unread_reg & ~(rd_data | RX_DMA_ACK)) | rx_move;
    full_next   = wr_data | (full_reg & ~tx_move);
    load_next   = tx_move;
    txdata_next = tx_move ? (txbuf_reg & wl_mask(word_len)) : TX_DATA;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and DMA requests.

  always @* begin
    tx_ev = mask_reg[`SISB_M_BSN] ? pend_reg[`SISB_P_HEM]
                                  : pend_reg[`SISB_P_SEM];
    req_err = mask_reg[`SISB_M_ERR] &
              (pend_reg[`SISB_P_OVR] | pend_reg[`SISB_P_FRM] |
               pend_reg[`SISB_P_PAR]);
    req_brkadr = (mask_reg[`SISB_M_ADR] & pend_reg[`SISB_P_ADR]) |
                 (mask_reg[`SISB_M_BRK] & pend_reg[`SISB_P_BRK]);
    req_rxd = mask_reg[`SISB_M_RXW] &
              (mask_reg[`SISB_M_REOB] |
               (pend_reg[`SISB_P_WRD] & ~rxdma_en));
    req_tx = mask_reg[`SISB_M_TXW] &
             (mask_reg[`SISB_M_TEOB] | (tx_ev & ~txdma_en));
    irq_next   = src_any;
    // Receive DMA stalls while any receive error flag is pending.
    rxreq_next = rxdma_en & pend_reg[`SISB_P_WRD] &
                 ~(pend_reg[`SISB_P_OVR] | pend_reg[`SISB_P_FRM] |
                   pend_reg[`SISB_P_PAR]);
    txreq_next = txdma_en & tx_ev & ~full_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  always @* begin
    rdata_next = `SISB_BYTE_ZERO;
    if (RD) begin
      case (ADDR)
        `SISB_OFS_VEC:   rdata_next = {base_reg, src_code, 1'b0};
        `SISB_OFS_MATCH: rdata_next = match_reg;
        `SISB_OFS_MASK:  rdata_next = mask_reg;
        `SISB_OFS_PEND:  rdata_next = pend_reg;
        `SISB_OFS_DATA:  rdata_next = rxbuf_reg;
        `SISB_OFS_CTRL:  rdata_next = ctrl_reg;
        `SISB_OFS_FMT:   rdata_next = fmt_reg;
        default:         rdata_next = `SISB_BYTE_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops.

  always @(posedge CLK) begin
    if (SRST) begin
      base_reg   <= `SISB_BASE_RST;
      match_reg  <= `SISB_BYTE_ZERO;
      mask_reg   <= `SISB_MASK_RST;
      pend_reg   <= `SISB_PEND_RST;
      rxbuf_reg  <= `SISB_BYTE_ZERO;
      txbuf_reg  <= `SISB_BYTE_ZERO;
      ctrl_reg   <= `SISB_CTRL_RST;
      fmt_reg    <= `SISB_FMT_RST;
      unread_reg <= 1'b0;
      full_reg   <= 1'b0;
      RDATA      <= `SISB_BYTE_ZERO;
      TX_LOAD    <= 1'b0;
      TX_DATA    <= `SISB_BYTE_ZERO;
      RX_DMA_REQ <= 1'b0;
      TX_DMA_REQ <= 1'b0;
      IRQ        <= 1'b0;
    end else begin
      base_reg   <= base_next;
      match_reg  <= match_next;
      mask_reg   <= mask_next;
      pend_reg   <= pend_next;
      rxbuf_reg  <= rxbuf_next;
      txbuf_reg  <= txbuf_next;
      ctrl_reg   <= ctrl_next;
      fmt_reg    <= fmt_next;
      unread_reg <= unread_next;
      full_reg   <= full_next;
      RDATA      <= rdata_next;
      TX_LOAD    <= load_next;
      TX_DATA    <= txdata_next;
      RX_DMA_REQ <= rxreq_next;
      TX_DMA_REQ <= txreq_next;
      IRQ        <= irq_next;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/sisb_top_asserts.sv
// Concurrent checks on the serial unit's register, transmit and DMA ports.
`timescale 1ns/1ns
`default_nettype none
module sisb_top_asserts (
  // Clock and reset.
  input wire logic       CLK,
  input wire logic       SRST,
  // Register port.
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Transmit, DMA and interrupt side.
  input wire logic       TX_SHIFT_FREE,
  input wire logic       TX_LOAD,
  input wire logic [7:0] TX_DATA,
  input wire logic       RX_DMA_ZERO,
  input wire logic       TX_DMA_ZERO,
  input wire logic       RX_DMA_REQ,
  input wire logic       TX_DMA_REQ,
  input wire logic       IRQ
);
  logic [4:0] base_reg;
  logic [7:0] match_reg;
  logic [5:0] mask_reg;
  logic       ctl_wr;
  logic       mz;
  ////////////////////////////////////////
  // Shadows of the fields only software writes.
  always @(posedge CLK) begin
    if (SRST) begin
      base_reg <= 5'h00;
      match_reg <= 8'h00;
      mask_reg <= 6'h00;
    end else if (WR) begin
      if (ADDR == 8'hF4)
        base_reg <= WDATA[7:3];
      if (ADDR == 8'hF5)
        match_reg <= WDATA;
      if (ADDR == 8'hF6)
        mask_reg <= {WDATA[7], WDATA[4:0]};
    end
  end
  assign ctl_wr = WR && (ADDR == 8'hF9);
  assign mz = (mask_reg[4:0] == 5'h00);
  ////////////////////////////////////////
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (SRST);
  vec_read_a:
    assert property ($past(RD) && $past(ADDR) == 8'hF4 |->
      RDATA[7:3] == base_reg && !RDATA[0]) else $error("Vector read wrong.");
  match_read_a:
    assert property ($past(RD) && $past(ADDR) == 8'hF5 |->
      RDATA == match_reg) else $error("Match character read wrong.");
  mask_read_a:
    assert property ($past(RD) && $past(ADDR) == 8'hF6 |->
      {RDATA[7], RDATA[4:0]} == mask_reg) else $error("Mask read wrong.");
  irq_masked_a:
    assert property (mz && $past(mz) |-> !IRQ)
      else $error("Interrupt raised with every enable clear.");
  tx_pulse_a:
    assert property (TX_LOAD |=> !TX_LOAD) else $error("Load pulse too long.");
  tx_free_a:
    assert property (TX_LOAD |-> $past(TX_SHIFT_FREE))
      else $error("Shifter loaded while busy.");
  tx_hold_a:
    assert property (!TX_LOAD |-> $stable(TX_DATA))
      else $error("Transmit byte changed without a load.");
  rxdma_stop_a:
    assert property (RX_DMA_ZERO && !ctl_wr |-> ##2 !RX_DMA_REQ)
      else $error("Receive DMA request outlived the zero count.");
  txdma_stop_a:
    assert property (TX_DMA_ZERO && !ctl_wr |-> ##2 !TX_DMA_REQ)
      else $error("Transmit DMA request outlived the zero count.");
  cover property (IRQ);
  cover property (TX_LOAD);
  cover property (RX_DMA_ZERO ##2 !RX_DMA_REQ);
endmodule
bind sisb_top sisb_top_asserts chk (.CLK(CLK), .SRST(SRST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .TX_SHIFT_FREE(TX_SHIFT_FREE), .TX_LOAD(TX_LOAD), .TX_DATA(TX_DATA),
  .RX_DMA_ZERO(RX_DMA_ZERO), .TX_DMA_ZERO(TX_DMA_ZERO),
  .RX_DMA_REQ(RX_DMA_REQ), .TX_DMA_REQ(TX_DMA_REQ), .IRQ(IRQ));
`default_nettype wire

// ===== testbench/sisb_far_node.sv
// Model of the remote node behind the receive and transmit shifters.
`timescale 1ns/1ns
`default_nettype none
module sisb_far_node (
  // Clock and pace.
  input  wire logic       clk,
  input  wire logic       slow,
  // Transmit shifter side.
  input  wire logic       tx_load,
  input  wire logic [7:0] tx_data,
  output logic            tx_shift_free,
  output logic            tx_shift_done,
  // Receive shifter side.
  output logic            rx_word_done,
  output logic [7:0]      rx_shift,
  output logic            rx_ninth,
  output logic            rx_parity_bit,
  output logic            rx_stop_ok,
  output logic            rx_after_break,
  output logic            rx_break
);
  logic [7:0] got = 8'h00;
  int         busy = 0;
  initial begin
    {tx_shift_free, tx_shift_done, rx_word_done, rx_break} = 4'h8;
    {rx_shift, rx_ninth, rx_parity_bit, rx_stop_ok, rx_after_break} = 12'h000;
  end
  ////////////////////////////////////////
  // The shifter is busy a few cycles after each load.
  always @(posedge clk) begin
    tx_shift_done <= 1'b0;
    if (tx_load) begin
      got <= tx_data;
      tx_shift_free <= 1'b0;
      busy <= slow ? 12 : 2;
    end else if (busy == 1) begin
      tx_shift_free <= 1'b1;
      tx_shift_done <= 1'b1;
      busy <= 0;
    end else if (busy > 1)
      busy <= busy - 1;
  end
  task word(input logic [7:0] d, input logic n, s, p, a);
    @(posedge clk);
    {rx_shift, rx_ninth, rx_stop_ok, rx_parity_bit, rx_after_break} <=
      {d, n, s, p, a};
    rx_word_done <= 1'b1;
    @(posedge clk);
    rx_word_done <= 1'b0;
    {rx_shift, rx_ninth, rx_stop_ok, rx_parity_bit} <= {~d, ~n, ~s, ~p};
    @(posedge clk);
  endtask
  task brk;
    @(posedge clk);
    rx_break <= 1'b1;
    @(posedge clk);
    rx_break <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/sisb_top_bench.sv
// Self-checking bench of the serial unit's registers and buffers.
`timescale 1ns/1ns
`default_nettype none
module sisb_top_bench;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        dma_ack = 1'b0;
  logic        rx_zero = 1'b0;
  logic        tx_zero = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  rdata, rx_shift, tx_data, q;
  logic        rx_done, rx_ninth, rx_par, rx_stop, rx_ab, rx_brk;
  logic        tx_free, tx_sdone, tx_load, rx_req, tx_req, irq;
  int          fail_count = 0;
  int          num_checks = 0;
  logic [23:0] rows [8] = '{24'hF4FFFE, 24'hF40106, 24'hF5A5A5, 24'hF67F1F,
                            24'hF60000, 24'hF7FF00, 24'hFB5A00, 24'hF33300};
  initial forever #50 clk = ~clk;
  sisb_top dut (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .RX_WORD_DONE(rx_done), .RX_SHIFT(rx_shift),
    .RX_NINTH(rx_ninth), .RX_PARITY_BIT(rx_par), .RX_STOP_OK(rx_stop),
    .RX_AFTER_BREAK(rx_ab), .RX_BREAK(rx_brk), .TX_SHIFT_FREE(tx_free),
    .TX_SHIFT_DONE(tx_sdone), .TX_LOAD(tx_load), .TX_DATA(tx_data),
    .RX_DMA_ACK(dma_ack), .RX_DMA_ZERO(rx_zero), .TX_DMA_ZERO(tx_zero),
    .RX_DMA_REQ(rx_req), .TX_DMA_REQ(tx_req), .IRQ(irq));
  sisb_far_node far (.clk(clk), .slow(slow), .tx_load(tx_load),
    .tx_data(tx_data), .tx_shift_free(tx_free), .tx_shift_done(tx_sdone),
    .rx_word_done(rx_done), .rx_shift(rx_shift), .rx_ninth(rx_ninth),
    .rx_parity_bit(rx_par), .rx_stop_ok(rx_stop), .rx_after_break(rx_ab),
    .rx_break(rx_brk));
  ////////////////////////////////////////
  task give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task bus_rd(input logic [7:0] a);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task chk(input logic [7:0] a, m, e);
    bus_rd(a);
    cmp("register", e, q & m);
  endtask
  task chki(input logic e);
    repeat (3) @(posedge clk);
    #1 cmp("IRQ", {7'h00, e}, {7'h00, irq});
  endtask
  task tx(input logic [7:0] f, d, e);
    bus_wr(8'hFA, f);
    bus_wr(8'hF8, d);
    for (int i = 0; i < 40 && tx_sdone !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    cmp("shifted byte", e, far.got);
  endtask
  task pulse_zero(input logic r);
    @(posedge clk);
    {rx_zero, tx_zero} <= {r, ~r};
    @(posedge clk);
    {rx_zero, tx_zero} <= 2'b00;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    chk(8'hF6, 8'h9F, 8'h00);
    chk(8'hF7, 8'hFF, 8'h00);
    foreach (rows[i]) begin
      bus_wr(rows[i][23:16], rows[i][15:8]);
      chk(rows[i][23:16], 8'hFF, rows[i][7:0]);
    end
    bus_wr(8'hFA, 8'h01);
    far.word(8'h15, 0, 1, 0, 0);
    chk(8'hF7, 8'hFC, 8'h04);
    chk(8'hF8, 8'hFF, 8'hD5);
    far.word(8'h2A, 0, 1, 0, 0);
    far.word(8'h0F, 0, 1, 0, 0);
    chk(8'hF7, 8'hFC, 8'h84);
    chk(8'hF8, 8'hFF, 8'hCF);
    bus_wr(8'hF6, 8'h02);
    chki(1'b1);
    chk(8'hF4, 8'hFF, 8'h04);
    bus_wr(8'hF7, 8'h7F);
    chk(8'hF7, 8'hFC, 8'h04);
    bus_wr(8'hF7, 8'h00);
    chki(1'b0);
    bus_wr(8'hF6, 8'h10);
    far.word(8'h33, 0, 0, 0, 0);
    chk(8'hF7, 8'hFC, 8'h44);
    chki(1'b1);
    chk(8'hF4, 8'hFF, 8'h00);
    chk(8'hF8, 8'hFF, 8'hF3);
    bus_wr(8'hF7, 8'h00);
    bus_wr(8'hFA, 8'h63);
    far.word(8'h01, 0, 1, 0, 0);
    chk(8'hF7, 8'hE0, 8'h20);
    bus_wr(8'hF7, 8'h00);
    bus_rd(8'hF8);
    far.word(8'h03, 0, 1, 0, 0);
    chk(8'hF7, 8'hE0, 8'h00);
    bus_wr(8'hF7, 8'h00);
    bus_wr(8'hF6, 8'h04);
    far.brk;
    chk(8'hF7, 8'h08, 8'h08);
    chki(1'b1);
    chk(8'hF4, 8'hFF, 8'h02);
    bus_wr(8'hF7, 8'h00);
    bus_wr(8'hF6, 8'h08);
    bus_wr(8'hF5, 8'hA5);
    bus_wr(8'hF9, 8'h80);
    bus_wr(8'hFA, 8'h03);
    far.word(8'hA5, 1, 1, 0, 0);
    chk(8'hF7, 8'h14, 8'h10);
    chki(1'b1);
    far.word(8'h11, 0, 1, 0, 0);
    chk(8'hF8, 8'hFF, 8'h11);
    far.word(8'h77, 1, 1, 0, 0);
    far.word(8'h22, 0, 1, 0, 0);
    chk(8'hF8, 8'hFF, 8'h11);
    far.word(8'h5C, 1, 0, 0, 0);
    chk(8'hF8, 8'hFF, 8'h5C);
    bus_wr(8'hF9, 8'h00);
    bus_wr(8'hFA, 8'h83);
    bus_wr(8'hF7, 8'h00);
    far.word(8'hA5, 0, 1, 0, 0);
    chk(8'hF7, 8'h14, 8'h10);
    bus_wr(8'hF7, 8'h00);
    bus_wr(8'hF9, 8'h80);
    far.word(8'hA5, 0, 1, 0, 1);
    far.word(8'h66, 0, 1, 0, 0);
    chk(8'hF7, 8'h14, 8'h14);
    chk(8'hF8, 8'hFF, 8'h66);
    bus_wr(8'hF9, 8'h00);
    bus_wr(8'hF7, 8'h00);
    bus_wr(8'hF6, 8'h81);
    slow <= 1'b1;
    tx(8'h03, 8'h5A, 8'h5A);
    chk(8'hF7, 8'h03, 8'h03);
    chki(1'b1);
    bus_wr(8'hF7, 8'hFD);
    chki(1'b0);
    bus_wr(8'hF6, 8'h01);
    chki(1'b1);
    slow <= 1'b0;
    tx(8'h00, 8'hFF, 8'h1F);
    bus_wr(8'hF7, 8'h00);
    bus_wr(8'hF6, 8'h02);
    bus_wr(8'hF9, 8'h10);
    bus_rd(8'hF8);
    far.word(8'h44, 0, 1, 0, 0);
    repeat (2) @(posedge clk);
    #1 cmp("rx DMA request", 8'h01, {7'h00, rx_req});
    chki(1'b0);
    @(posedge clk);
    dma_ack <= 1'b1;
    @(posedge clk);
    dma_ack <= 1'b0;
    pulse_zero(1'b1);
    chk(8'hF9, 8'h10, 8'h00);
    chk(8'hF6, 8'h40, 8'h40);
    chki(1'b1);
    bus_wr(8'hF6, 8'h02);
    chk(8'hF6, 8'h40, 8'h00);
    bus_wr(8'hF9, 8'h08);
    tx(8'h03, 8'hC3, 8'hC3);
    repeat (2) @(posedge clk);
    #1 cmp("tx DMA request", 8'h01, {7'h00, tx_req});
    pulse_zero(1'b0);
    chk(8'hF9, 8'h08, 8'h00);
    cmp("tx DMA request", 8'h00, {7'h00, tx_req});
    chk(8'hF6, 8'h20, 8'h20);
    give_verdict;
  end
endmodule
`default_nettype wire
